// [rtl/sfe_params.svh]
// Constants for the stream fetch engine: widths, codes, reset values.
// Assumes inclusion from the package, the engine and the memory model.
`ifndef SFE_PARAMS_SVH
`define SFE_PARAMS_SVH

// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define SFE_DW        32
`define SFE_AW        32
`define SFE_CW        16
`define SFE_MW        2

// ---------------------------------------------------------------
// Codes and reset values
// ---------------------------------------------------------------
`define SFE_ADDR_STEP 32'h0000_0004
`define SFE_CNT_ONE   16'h0001
`define SFE_CNT_ZERO  16'h0000
`define SFE_FILL_OFF  2'h0
`define SFE_ERR_NONE  2'h0
`define SFE_DATA_ZERO 32'h0000_0000
`define SFE_ADDR_ZERO 32'h0000_0000

`endif

// [rtl/sfe_pkg.sv]
// Types shared by the stream fetch engine and its bench.
// Assumes sfe_params.svh is on the include path.
`include "sfe_params.svh"

package sfe_pkg;

   // ---------------------------------------------------------------
   // Stream setup, latched on start
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [`SFE_AW-1:0] base;
      logic [`SFE_CW-1:0] count;
      logic [`SFE_MW-1:0] fill_value_mode;
      logic [`SFE_DW-1:0] fill_data;
   } sfe_cfg_t;

   // ---------------------------------------------------------------
   // Fetch response: err 0 ok, 1 translation fault, 2/3 memory error
   // ---------------------------------------------------------------
   typedef struct packed {
      logic               valid;
      logic [`SFE_MW-1:0] err;
      logic [`SFE_DW-1:0] data;
   } sfe_resp_t;

   // ---------------------------------------------------------------
   // Stream reference presented to the core
   // ---------------------------------------------------------------
   typedef struct packed {
      logic               valid;
      logic               err;
      logic               eos;
      logic [`SFE_DW-1:0] data;
   } sfe_ref_t;

   typedef enum logic [2:0] {
      SFE_IDLE, SFE_REQ, SFE_WAIT, SFE_PUSH, SFE_HALT, SFE_BRK, SFE_EOS
   } sfe_state_t;

endpackage

// [rtl/sfe_engine.sv]
// Stream engine fetch, error and break handling.
// Assumes single-clock partners: fetch port, memory side and core.
// How it works
// (R1) An error response on the active fetch halts the fetch machine unless a break comes in the same cycle.
// (R2) A stream break always ends by restarting that same fetch machine.
// (R3) Errors reach the core as references carrying all-zero data.
// (R4) Sticky error-pending flag drives active-low clear of output register.
// (R5) Break clears the sticky flag before any later reference is pushed.
// (R6) Non-zero fill mode gives fill data on every end-of-stream reference.
// (R7) Core reset returns the engine from any state to idle.
// (R8) Error and break at any relative timing still restart the machine.
`timescale 1ns/1ps
`include "sfe_params.svh"

module sfe_engine
   import sfe_pkg::*;
(
   input  wire logic               i_clk,
   input  wire logic               i_rstn,
   input  wire logic               i_start,
   input  wire sfe_cfg_t           i_cfg,
   input  wire logic               i_break,
   input  wire logic               i_fetch_ready,
   input  wire sfe_resp_t          i_resp,
   input  wire logic               i_ref_pop,
   output logic                    o_fetch_valid,
   output logic [`SFE_AW-1:0]      o_fetch_addr,
   output sfe_ref_t                o_ref,
   output logic                    o_err_pending,
   output logic                    o_busy
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   sfe_state_t          state_reg, state_next;
   sfe_cfg_t            cfg_reg;
   logic [`SFE_CW-1:0]  cnt_reg, cnt_next;
   logic [`SFE_AW-1:0]  addr_reg, addr_next;
   logic                outst_reg, outst_next;
   logic                errp_reg, errp_next;
   sfe_ref_t            ref_reg, ref_next;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   wire logic brk      = i_break && (state_reg != SFE_IDLE);
   // Handshake counts in a break cycle too, so its answer is drained
   wire logic fire     = (state_reg == SFE_REQ) && i_fetch_ready;
   wire logic resp_in  = (state_reg == SFE_WAIT) && i_resp.valid && !brk;
   wire logic resp_bad = resp_in && (i_resp.err != `SFE_ERR_NONE);
   wire logic resp_ok  = resp_in && (i_resp.err == `SFE_ERR_NONE);
   wire logic popped   = ref_reg.valid && i_ref_pop;
   wire logic start_ok = i_start && (state_reg == SFE_IDLE
                                     || state_reg == SFE_EOS);
   wire logic load_eos = (state_reg == SFE_EOS) && !brk
                         && (!ref_reg.valid || i_ref_pop);
   wire logic fill_on  = (cfg_reg.fill_value_mode != `SFE_FILL_OFF);
   wire logic [`SFE_DW-1:0] eos_data = fill_on ? cfg_reg.fill_data
                                               : `SFE_DATA_ZERO;
   // Error set and break clear never meet: a break cycle drops the response first
   wire logic errp_set = resp_bad;                               // see R1
   // Clear computed from next flag so the error reference is zeroed in the cycle it is pushed
   wire logic clr_n    = !errp_next;                             // see R4
   wire logic [`SFE_DW-1:0] ld_data = resp_ok ? i_resp.data : eos_data;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      addr_next  = addr_reg;
      case (state_reg)
         SFE_IDLE: begin
            if (i_start) begin
               cnt_next   = i_cfg.count;
               addr_next  = i_cfg.base;
               state_next = (i_cfg.count == `SFE_CNT_ZERO) ? SFE_EOS
                                                           : SFE_REQ;
            end
         end
         SFE_REQ: begin
            if (fire) begin
               state_next = SFE_WAIT;
            end
         end
         SFE_WAIT: begin
            if (resp_bad) begin
               state_next = SFE_HALT;                            // see R1
            end else if (resp_ok) begin
               state_next = SFE_PUSH;
               addr_next  = addr_reg + `SFE_ADDR_STEP;
               cnt_next   = cnt_reg - `SFE_CNT_ONE;
            end
         end
         SFE_PUSH: begin
            if (popped) begin
               state_next = (cnt_reg == `SFE_CNT_ZERO) ? SFE_EOS : SFE_REQ;
            end
         end
         SFE_HALT: begin
            state_next = SFE_HALT;                               // see R1
         end
         SFE_BRK: begin
            // Wait out the in-flight fetch, then restart       see R2
            if (!outst_reg) begin
               state_next = SFE_EOS;
            end
         end
         SFE_EOS: begin
            if (i_start) begin
               cnt_next   = i_cfg.count;
               addr_next  = i_cfg.base;
               state_next = (i_cfg.count == `SFE_CNT_ZERO) ? SFE_EOS
                                                           : SFE_REQ;
            end
         end
         default: begin
            state_next = SFE_IDLE;
         end
      endcase
      // Break overrides every state but idle, so no timing can strand it  see R8
      if (brk) begin
         state_next = SFE_BRK;
      end
   end

   // Outstanding fetch flag tracks the handshake across a break
   always_comb begin
      outst_next = outst_reg;
      if (fire) begin
         outst_next = 1'b1;
      end else if (outst_reg && i_resp.valid) begin
         outst_next = 1'b0;
      end
   end

   // Sticky error flag; break clears it before any eos push   see R5
   always_comb begin
      errp_next = errp_reg;
      if (brk) begin
         errp_next = 1'b0;
      end else if (errp_set) begin
         errp_next = 1'b1;
      end
   end

   // Output register with its active-low clear
   always_comb begin
      ref_next = ref_reg;
      if (brk || start_ok) begin
         ref_next.valid = 1'b0;
      end else if (resp_bad) begin
         ref_next.valid = 1'b1;                                 // see R3
         ref_next.err   = 1'b1;
         ref_next.eos   = 1'b0;
      end else if (resp_ok || load_eos) begin
         ref_next.valid = 1'b1;
         ref_next.err   = 1'b0;
         ref_next.eos   = load_eos;
         ref_next.data  = ld_data;                              // see R6
      end else if (popped) begin
         ref_next.valid = 1'b0;
      end
      if (!clr_n) begin
         ref_next.data = `SFE_DATA_ZERO;                        // see R4
      end
   end

   // ---------------------------------------------------------------
   // Registers; core reset recovers any hang
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg <= SFE_IDLE;                                 // see R7
         cnt_reg   <= `SFE_CNT_ZERO;
         addr_reg  <= `SFE_ADDR_ZERO;
         outst_reg <= 1'b0;
         errp_reg  <= 1'b0;
         ref_reg   <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         addr_reg  <= addr_next;
         outst_reg <= outst_next;
         errp_reg  <= errp_next;
         ref_reg   <= ref_next;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cfg_reg <= '0;
      end else if (start_ok) begin
         cfg_reg <= i_cfg;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_fetch_valid <= 1'b0;
         o_fetch_addr  <= `SFE_ADDR_ZERO;
         o_busy        <= 1'b0;
      end else begin
         o_fetch_valid <= (state_next == SFE_REQ);
         o_fetch_addr  <= addr_next;
         o_busy        <= (state_next != SFE_IDLE);
      end
   end

   assign o_ref         = ref_reg;
   assign o_err_pending = errp_reg;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_err_halts;
      @(posedge i_clk) disable iff (!i_rstn)
      (state_reg == SFE_WAIT && i_resp.valid && i_resp.err != `SFE_ERR_NONE
       && !i_break) |=> (state_reg == SFE_HALT) && errp_reg;
   endproperty
   a_err_halts: assert property (p_err_halts)                   // see R1
      else $error("error response did not halt fetch");

   property p_halt_holds;
      @(posedge i_clk) disable iff (!i_rstn)
      (state_reg == SFE_HALT && !i_break) |=> state_reg == SFE_HALT;
   endproperty
   a_halt_holds: assert property (p_halt_holds)                 // see R1
      else $error("halted fetch moved without break");

   property p_brk_restart;
      @(posedge i_clk) disable iff (!i_rstn)
      (state_reg == SFE_BRK && !outst_reg && !i_break)
      |=> state_reg == SFE_EOS ##1 o_ref.valid;
   endproperty
   a_brk_restart: assert property (p_brk_restart)               // see R2
      else $error("break did not restart fetch");

   property p_err_zero;
      @(posedge i_clk) disable iff (!i_rstn)
      (o_ref.valid && o_ref.err) |-> o_ref.data == `SFE_DATA_ZERO;
   endproperty
   a_err_zero: assert property (p_err_zero)                     // see R3
      else $error("error reference carries data");

   property p_clear_zero;
      @(posedge i_clk) disable iff (!i_rstn)
      $rose(errp_reg) |-> o_ref.valid && o_ref.err
      && o_ref.data == `SFE_DATA_ZERO;
   endproperty
   a_clear_zero: assert property (p_clear_zero)                 // see R4
      else $error("sticky error did not zero output");

   property p_brk_clears;
      @(posedge i_clk) disable iff (!i_rstn)
      (i_break && state_reg != SFE_IDLE) |=> !errp_reg && !o_ref.valid;
   endproperty
   a_brk_clears: assert property (p_brk_clears)                 // see R5
      else $error("break left error pending");

   property p_fill;
      @(posedge i_clk) disable iff (!i_rstn)
      (o_ref.valid && o_ref.eos && cfg_reg.fill_value_mode != `SFE_FILL_OFF)
      |-> o_ref.data == cfg_reg.fill_data;
   endproperty
   a_fill: assert property (p_fill)                             // see R6
      else $error("eos reference lost fill data");

   property p_idle_quiet;
      @(posedge i_clk) disable iff (!i_rstn)
      (state_reg == SFE_IDLE) |-> !o_fetch_valid && !o_busy && !errp_reg;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)                 // see R7
      else $error("idle engine not quiet");

   property p_brk_any;
      @(posedge i_clk) disable iff (!i_rstn)
      (i_break && state_reg != SFE_IDLE) |=> state_reg == SFE_BRK;
   endproperty
   a_brk_any: assert property (p_brk_any)                       // see R8
      else $error("break lost in some state");

endmodule

// [verif/sfe_mem_model.sv]
// Fetch-side model: takes one request, answers after one or three cycles.
// Assumes the engine keeps one fetch outstanding at a time.
`timescale 1ns/1ps
`include "sfe_params.svh"

module sfe_mem_model
   import sfe_pkg::*;
(
   input  wire logic               i_clk,
   input  wire logic               i_rstn,
   input  wire logic               i_fetch_valid,
   input  wire logic [`SFE_AW-1:0] i_fetch_addr,
   input  wire logic [`SFE_MW-1:0] i_err,
   input  wire logic               i_slow,
   output logic                    o_ready,
   output sfe_resp_t               o_resp
);
   logic               pend_reg;
   logic               tick_reg;
   logic [1:0]         cnt_reg;
   logic [`SFE_AW-1:0] addr_reg;

   // Slow mode stalls the handshake every other cycle
   assign o_ready = ~pend_reg & (~i_slow | tick_reg);

   // ----
   // Answer, error code chosen by the bench
   // ----
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pend_reg <= 1'b0;
         tick_reg <= 1'b0;
         cnt_reg  <= 2'h0;
         addr_reg <= 32'h0000_0000;
         o_resp   <= '0;
      end else begin
         tick_reg     <= ~tick_reg;
         o_resp.valid <= 1'b0;
         // Idle data keeps moving so no stale word looks valid
         o_resp.data  <= ~o_resp.data;
         if (i_fetch_valid & o_ready) begin
            pend_reg <= 1'b1;
            addr_reg <= i_fetch_addr;
            cnt_reg  <= i_slow ? 2'h2 : 2'h0;
         end else if (pend_reg && cnt_reg == 2'h0) begin
            pend_reg <= 1'b0;
            o_resp   <= '{valid: 1'b1, err: i_err,
                          data: addr_reg ^ 32'h5A5A_0000};
         end else if (pend_reg) begin
            cnt_reg <= cnt_reg - 2'h1;
         end
      end
   end
endmodule

// [verif/tb.sv]
// Bench for sfe_engine: stream table, break timing, mid-run reset.
// Assumes sfe_mem_model on the fetch side; the bench acts as the core.
`timescale 1ns/1ps

module tb
   import sfe_pkg::*;
;
   typedef struct packed {
      logic [1:0]  mode;
      logic [1:0]  err;
      logic [31:0] fill;
      logic        exp_err;
      logic [31:0] exp_eos;
   } sfe_row_t;

   localparam logic [31:0] BASE = 32'h0000_1000;
   localparam logic [31:0] DATA = 32'h5A5A_1000;

   logic        i_clk = 1'b0;
   logic        i_rstn = 1'b0;
   logic        i_start = 1'b0;
   logic        i_break = 1'b0;
   logic        i_ref_pop = 1'b0;
   logic        slow = 1'b0;
   logic [1:0]  err_code = 2'h0;
   sfe_cfg_t    cfg = '0;
   logic        fetch_valid;
   logic        ready;
   logic [31:0] addr;
   sfe_resp_t   resp;
   sfe_ref_t    ref_o;
   logic        err_pending;
   logic        busy;
   int          err_count = 0;
   int          samples_checked = 0;
   sfe_row_t    rows [5] = '{
      '{2'h1, 2'h0, 32'hA5A5_0001, 1'b0, 32'hA5A5_0001},
      '{2'h2, 2'h1, 32'h0000_BEEF, 1'b1, 32'h0000_BEEF},
      '{2'h3, 2'h2, 32'h1234_5678, 1'b1, 32'h1234_5678},
      '{2'h0, 2'h3, 32'hFFFF_FFFF, 1'b1, 32'h0000_0000},
      '{2'h0, 2'h0, 32'hFFFF_0000, 1'b0, 32'h0000_0000}};

   always #2 i_clk = ~i_clk;

   sfe_engine dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_start(i_start),
      .i_cfg(cfg), .i_break(i_break), .i_fetch_ready(ready),
      .i_resp(resp), .i_ref_pop(i_ref_pop), .o_fetch_valid(fetch_valid),
      .o_fetch_addr(addr), .o_ref(ref_o), .o_err_pending(err_pending),
      .o_busy(busy));

   sfe_mem_model mem_u (.i_clk(i_clk), .i_rstn(i_rstn),
      .i_fetch_valid(fetch_valid), .i_fetch_addr(addr), .i_err(err_code),
      .i_slow(slow), .o_ready(ready), .o_resp(resp));

   // ----
   // Tasks
   // ----
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("checked %0d mismatched %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic start_n(input logic [1:0] m, input logic [31:0] f,
                          input logic [1:0] e, input logic [15:0] c);
      @(posedge i_clk);
      cfg      <= '{BASE, c, m, f};
      err_code <= e;
      i_start  <= 1'b1;
      @(posedge i_clk);
      i_start  <= 1'b0;
   endtask

   task automatic start_s(input logic [1:0] m, input logic [31:0] f,
                          input logic [1:0] e);
      start_n(m, f, e, 16'h0001);
   endtask

   task automatic brk();
      @(posedge i_clk) i_break <= 1'b1;
      @(posedge i_clk) i_break <= 1'b0;
   endtask

   task automatic pop();
      @(posedge i_clk) i_ref_pop <= 1'b1;
      @(posedge i_clk) i_ref_pop <= 1'b0;
   endtask

   // Bounded wait; a hung fetch machine shows up here
   task automatic wait_ref(input logic want_eos);
      int n;
      n = 0;
      @(negedge i_clk);
      while (!(ref_o.valid === 1'b1 && (ref_o.eos === 1'b1 || !want_eos))
             && n < 60) begin
         @(negedge i_clk);
         n++;
      end
      if (n >= 60) chk(32'h0000_0000, 32'h0000_0001);
   endtask

   initial begin
      #40000;
      err_count++;
      results();
   end

   // ----
   // Tests
   // ----
   initial begin
      repeat (6) @(posedge i_clk);
      i_rstn <= 1'b1;
      foreach (rows[i]) begin
         start_s(rows[i].mode, rows[i].fill, rows[i].err);
         wait_ref(1'b0);
         chk(ref_o.err, rows[i].exp_err);
         chk(ref_o.data, rows[i].exp_err ? 32'h0000_0000 : DATA);
         chk(err_pending, rows[i].exp_err);
         if (rows[i].exp_err) begin
            brk();
            @(negedge i_clk);
            chk(err_pending, 1'b0);
         end else begin
            pop();
         end
         wait_ref(1'b1);
         chk(ref_o.data, rows[i].exp_eos);
         pop();
         pop();
         @(negedge i_clk);
         chk(ref_o.data, rows[i].exp_eos);
      end
      // Break at six offsets after the fetch handshake, up to and past its error answer
      for (int d = 0; d < 6; d++) begin
         @(posedge i_clk) slow <= d[0];
         start_s(2'h1, 32'hC0DE_0000 + 32'(d), 2'h1);
         repeat (d) @(posedge i_clk);
         brk();
         wait_ref(1'b1);
         chk(ref_o.data, 32'hC0DE_0000 + 32'(d));
         chk(err_pending, 1'b0);
      end
      start_s(2'h2, 32'h0000_0F0F, 2'h2);
      wait_ref(1'b0);
      @(posedge i_clk) i_rstn <= 1'b0;
      @(negedge i_clk);
      chk({busy, err_pending, ref_o.valid, fetch_valid}, 4'h0);
      @(posedge i_clk) i_rstn <= 1'b1;
      start_s(2'h3, 32'h0000_7777, 2'h0);
      wait_ref(1'b0);
      chk(ref_o.data, DATA);
      pop();
      wait_ref(1'b1);
      chk(ref_o.data, 32'h0000_7777);
      // Two-word stream started from eos, then an empty stream
      start_n(2'h1, 32'h0000_3333, 2'h0, 16'h0002);
      wait_ref(1'b0);
      chk(ref_o.data, DATA);
      chk(busy, 1'b1);
      pop();
      wait_ref(1'b0);
      chk(ref_o.data, DATA + 32'h0000_0004);
      pop();
      wait_ref(1'b1);
      chk(ref_o.data, 32'h0000_3333);
      start_n(2'h2, 32'h0000_4444, 2'h0, 16'h0000);
      wait_ref(1'b1);
      chk(ref_o.data, 32'h0000_4444);
      results();
   end
endmodule
